// >>> src/io_port_pkg.sv
// Constants, register map and carrier types for the six-bit I/O port.
// Assumes a single core clock and an APB register bus with 32-bit data.
// Functional notes
// - Output latch write equals level register write
// - Latch reads latch; level reads sampled pins
// - Direction one makes pin input, driver off
// - Direction zero drives latch value onto pin
// - Port is six bits, one input-only
// - Pin three input-only; direction reads one
// - Port writes merge written bits over sampled pins
// - Pin three reads zero under master clear enable
// - Direction bits still govern analog pins
// - Analog pins read zero digitally
// - Analog pins cannot raise change events
// - Analog select disables digital input buffer
// - Outputs still drive pins in analog mode
// - Highest enabled peripheral wins; latch lowest
// - Analog path needs peripheral enable and mux
// - Gate pin select picks pin three or four
// - Steering leaves direction bits, unselected pin alone
// - Unused steering bits read zero, ignore writes
// - Peripheral-owned pin denies general-purpose use
// - Analog select bits reset to analog
package io_port_pkg;

  localparam int PORT_WIDTH = 6;
  localparam int PERIPH_SLOTS = 3;
  localparam int INPUT_ONLY_PIN = 3;
  localparam int GATE_ALT_PIN = 3;
  localparam int GATE_DEF_PIN = 4;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h00;
  localparam logic [7:0] OFS_DIRECTION = 8'h04;
  localparam logic [7:0] OFS_OUT_LATCH = 8'h08;
  localparam logic [7:0] OFS_ANALOG_SEL = 8'h0c;
  localparam logic [7:0] OFS_STEERING = 8'h10;

  // Steering register field
  localparam int GATE_SEL_BIT = 4;

  // Reset values
  localparam logic [5:0] DIRECTION_RST = 6'h3f;
  localparam logic [5:0] OUT_LATCH_RST = 6'h00;
  localparam logic [5:0] ANALOG_SEL_RST = 6'h3f;
  localparam logic GATE_SEL_RST = 1'b0;

  // Writable latch and direction bits; pin three has none
  localparam logic [5:0] WRITABLE_MASK = 6'h37;

  // Peripheral drive requests for one pin, slot zero is highest
  typedef struct packed {
    logic [PERIPH_SLOTS-1:0] en;
    logic [PERIPH_SLOTS-1:0] dat;
  } periph_drive_t;

  // Analog input request for one pin
  typedef struct packed {
    logic periph_en;
    logic mux_sel;
  } analog_req_t;

endpackage : io_port_pkg

// >>> src/io_port.sv
// Six-bit general-purpose port with pin steering and output priority.
// Assumes pins arrive asynchronously; peripheral requests and the master
// clear enable come from core-clock logic.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module io_port (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pins
  input wire logic [5:0] pin_in_i,
  output logic [5:0] pin_out_o,
  output logic [5:0] pin_oe_o,
  output logic [5:0] input_buf_en_o,
  // Peripheral side
  input wire io_port_pkg::periph_drive_t [5:0] periph_drive_i,
  input wire io_port_pkg::analog_req_t [5:0] analog_req_i,
  input wire logic master_clear_pin_enable_i,
  output logic [5:0] analog_path_en_o,
  output logic [5:0] digital_in_o,
  output logic timer_gate_input_o
);

  // Highest-priority enabled slot and its data
  function automatic logic pick_first(
    input logic [io_port_pkg::PERIPH_SLOTS-1:0] en,
    input logic [io_port_pkg::PERIPH_SLOTS-1:0] dat
  );
    logic r;
    r = 1'b0;
    for (int s = io_port_pkg::PERIPH_SLOTS - 1; s >= 0; s--) begin
      if (en[s]) begin
        r = dat[s];
      end
    end
    return r;
  endfunction : pick_first

  logic [5:0] pin_meta_q;
  logic [5:0] pin_sync_q;
  logic [5:0] direction_reg_q;
  logic [5:0] output_latch_reg_q;
  logic [5:0] analog_select_reg_q;
  logic gate_pin_select_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [5:0] pin_out_q;
  logic [5:0] pin_oe_q;
  logic [5:0] input_buf_en_q;
  logic [5:0] analog_path_en_q;
  logic [5:0] digital_in_q;
  logic timer_gate_q;

  logic [5:0] digital_in_d;
  logic [5:0] level_read;
  logic [5:0] direction_read;
  logic [5:0] latch_read;
  logic [7:0] steering_read;
  logic setup_phase;
  logic access_write;
  logic addr_hit;
  logic [31:0] read_data;
  logic [5:0] port_write_val;
  logic [5:0] pin_out_d;
  logic [5:0] pin_oe_d;

  // Two-flop pin synchroniser
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pin_meta_q <= 6'h00;
      pin_sync_q <= 6'h00;
    end else if (clk_en_i) begin
      pin_meta_q <= pin_in_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Digital view of the pins, analog pins forced low
  always_comb begin
    digital_in_d = pin_sync_q & ~analog_select_reg_q;
    level_read = digital_in_d;
    if (master_clear_pin_enable_i) begin
      level_read[io_port_pkg::INPUT_ONLY_PIN] = 1'b0;
    end
    direction_read = direction_reg_q;
    direction_read[io_port_pkg::INPUT_ONLY_PIN] = 1'b1;
    latch_read = output_latch_reg_q & io_port_pkg::WRITABLE_MASK;
    steering_read = 8'h00;
    steering_read[io_port_pkg::GATE_SEL_BIT] = gate_pin_select_q;
  end

  // Bus decode
  assign setup_phase = psel_i & ~penable_i;
  assign access_write = psel_i & penable_i & pready_q & pwrite_i;

  always_comb begin
    addr_hit = 1'b1;
    read_data = 32'h0000_0000;
    case (paddr_i)
      io_port_pkg::OFS_PIN_LEVEL: begin
        read_data[5:0] = level_read;
      end
      io_port_pkg::OFS_DIRECTION: begin
        read_data[5:0] = direction_read;
      end
      io_port_pkg::OFS_OUT_LATCH: begin
        read_data[5:0] = latch_read;
      end
      io_port_pkg::OFS_ANALOG_SEL: begin
        read_data[5:0] = analog_select_reg_q;
      end
      io_port_pkg::OFS_STEERING: begin
        read_data[7:0] = steering_read;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Ready one cycle after setup, read data captured with it
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (clk_en_i) begin
      pready_q <= setup_phase;
      if (setup_phase) begin
        prdata_q <= pwrite_i ? 32'h0000_0000 : read_data;
        pslverr_q <= ~addr_hit;
      end else begin
        prdata_q <= 32'h0000_0000;
        pslverr_q <= 1'b0;
      end
    end
  end

  // Written bits merged over the digital pin view; analog pins read zero
  always_comb begin
    port_write_val = pstrb_i[0] ? pwdata_i[5:0] : digital_in_d;
  end

  // Output latch, reached through both level and latch offsets
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      output_latch_reg_q <= io_port_pkg::OUT_LATCH_RST;
    end else if (clk_en_i && access_write) begin
      if (paddr_i == io_port_pkg::OFS_PIN_LEVEL ||
          paddr_i == io_port_pkg::OFS_OUT_LATCH) begin
        output_latch_reg_q <= port_write_val & io_port_pkg::WRITABLE_MASK;
      end
    end
  end

  // Direction register; pin three stays an input
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      direction_reg_q <= io_port_pkg::DIRECTION_RST;
    end else if (clk_en_i && access_write && pstrb_i[0] &&
                 paddr_i == io_port_pkg::OFS_DIRECTION) begin
      direction_reg_q <= (pwdata_i[5:0] & io_port_pkg::WRITABLE_MASK) |
                         ~io_port_pkg::WRITABLE_MASK;
    end
  end

  // Analog select, all analog after reset
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      analog_select_reg_q <= io_port_pkg::ANALOG_SEL_RST;
    end else if (clk_en_i && access_write && pstrb_i[0] &&
                 paddr_i == io_port_pkg::OFS_ANALOG_SEL) begin
      analog_select_reg_q <= pwdata_i[5:0];
    end
  end

  // Steering register holds only the gate pin select
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      gate_pin_select_q <= io_port_pkg::GATE_SEL_RST;
    end else if (clk_en_i && access_write && pstrb_i[0] &&
                 paddr_i == io_port_pkg::OFS_STEERING) begin
      gate_pin_select_q <= pwdata_i[io_port_pkg::GATE_SEL_BIT];
    end
  end

  // Per-pin output resolution
  generate
    for (genvar p = 0; p < io_port_pkg::PORT_WIDTH; p++) begin : g_pin
      logic owned;
      assign owned = |periph_drive_i[p].en;
      always_comb begin
        if (p == io_port_pkg::INPUT_ONLY_PIN) begin
          pin_out_d[p] = 1'b0;
          pin_oe_d[p] = 1'b0;
        end else if (owned) begin
          // Peripheral drives regardless of analog select
          pin_out_d[p] = pick_first(periph_drive_i[p].en,
                                    periph_drive_i[p].dat);
          pin_oe_d[p] = 1'b1;
        end else begin
          pin_out_d[p] = output_latch_reg_q[p];
          pin_oe_d[p] = ~direction_reg_q[p];
        end
      end
    end
  endgenerate

  // Registered pin drive
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pin_out_q <= 6'h00;
      pin_oe_q <= 6'h00;
    end else if (clk_en_i) begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  // Input buffer and analog path enables
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      input_buf_en_q <= 6'h00;
      analog_path_en_q <= 6'h00;
    end else if (clk_en_i) begin
      input_buf_en_q <= ~analog_select_reg_q;
      for (int p = 0; p < io_port_pkg::PORT_WIDTH; p++) begin
        analog_path_en_q[p] <= analog_req_i[p].periph_en &
                               analog_req_i[p].mux_sel;
      end
    end
  end

  // Digital inputs to change detection and the timer gate
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      digital_in_q <= 6'h00;
      timer_gate_q <= 1'b0;
    end else if (clk_en_i) begin
      digital_in_q <= digital_in_d;
      // Only the selected pin feeds the gate; direction untouched
      timer_gate_q <= gate_pin_select_q ?
                      digital_in_d[io_port_pkg::GATE_ALT_PIN] :
                      digital_in_d[io_port_pkg::GATE_DEF_PIN];
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign pin_out_o = pin_out_q;
  assign pin_oe_o = pin_oe_q;
  assign input_buf_en_o = input_buf_en_q;
  assign analog_path_en_o = analog_path_en_q;
  assign digital_in_o = digital_in_q;
  assign timer_gate_input_o = timer_gate_q;

endmodule : io_port

// >>> test/io_port_sva.sv
// Checker for io_port: bus answer timing, drive and input masking.
// Bound to io_port; sees only its ports.
`timescale 1ns/1ps
module io_port_sva (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [5:0] pin_out_o,
  input wire logic [5:0] pin_oe_o,
  input wire logic [5:0] input_buf_en_o,
  input wire io_port_pkg::periph_drive_t [5:0] periph_drive_i,
  input wire io_port_pkg::analog_req_t [5:0] analog_req_i,
  input wire logic [5:0] analog_path_en_o,
  input wire logic [5:0] digital_in_o
);
  logic [5:0] ana_req;
  logic go;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      ana_req[i] = analog_req_i[i].periph_en & analog_req_i[i].mux_sel;
    end
  end
  assign go = nrst_i & clk_en_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  a_ready_after_setup: assert property (
    go && psel_i && !penable_i |=> pready_o) else $error("no ready");
  a_ready_one_cycle: assert property (
    go && pready_o |=> !pready_o) else $error("ready too long");
  a_rdata_idle: assert property (
    !pready_o |-> prdata_o == 32'h0) else $error("stray read data");
  a_error_with_ready: assert property (
    pslverr_o |-> pready_o) else $error("error without ready");
  a_pin3_quiet: assert property (
    go && periph_drive_i[3].en == 3'h0 |=> !pin_oe_o[3])
    else $error("pin three driven");
  a_analog_path: assert property (
    go |=> analog_path_en_o == $past(ana_req)) else $error("analog path");
  a_slot_zero_wins: assert property (
    go && periph_drive_i[4].en[0] |=> pin_oe_o[4] &&
    pin_out_o[4] == $past(periph_drive_i[4].dat[0]))
    else $error("priority lost");
  a_analog_reads_zero: assert property (
    (digital_in_o & ~input_buf_en_o) == 6'h00) else $error("analog read");
  a_freeze_hold: assert property (
    !clk_en_i |=> $stable(pin_oe_o) && $stable(pin_out_o))
    else $error("pin drive moved while frozen");
  c_unmapped: cover property (pslverr_o);
  c_periph: cover property (pin_oe_o[4] && periph_drive_i[4].en[0]);
  c_analog: cover property (analog_path_en_o != 6'h00);
endmodule : io_port_sva

bind io_port io_port_sva chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .clk_en_i(clk_en_i), .psel_i(psel_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
  .input_buf_en_o(input_buf_en_o), .periph_drive_i(periph_drive_i),
  .analog_req_i(analog_req_i), .analog_path_en_o(analog_path_en_o),
  .digital_in_o(digital_in_o));

// >>> test/pin_model.sv
// Pad model: each pad follows the port when driven, else the outside.
// Outside level comes from the bench; no pull resistors.
`timescale 1ns/1ps
module pin_model (
  input wire logic [5:0] pin_out_i,
  input wire logic [5:0] pin_oe_i,
  input wire logic [5:0] ext_i,
  output logic [5:0] pad_o
);
  // Driven pads show the port, released pads the outside
  assign pad_o = (pin_out_i & pin_oe_i) | (ext_i & ~pin_oe_i);
endmodule : pin_model

// >>> test/six_bit_io_port_with_pin_steering_test.sv
// Bench for io_port: APB master, pad model, register table, edge cases.
// Assumes a 100 MHz core clock and synchronous active-low reset.
`timescale 1ns/1ps
module six_bit_io_port_with_pin_steering_test;
  typedef struct {logic [7:0] wa, wd, ra, ex;} row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic mcen = 1'b0;
  logic cen = 1'b1;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [3:0] pst = 4'h0;
  logic [5:0] ext = 6'h00;
  logic [31:0] prd, rd;
  logic rdy, serr, gate, re;
  logic [5:0] pout, poe, ibuf, apath, din, pad;
  io_port_pkg::periph_drive_t [5:0] pd = '0;
  io_port_pkg::analog_req_t [5:0] ar = '0;
  int err_count = 0;
  int total_checks = 0;
  row_t rows [7] = '{'{8'h10, 8'hff, 8'h10, 8'h10},
    '{8'h10, 8'h00, 8'h10, 8'h00}, '{8'h04, 8'h00, 8'h04, 8'h08},
    '{8'h0c, 8'h00, 8'h0c, 8'h00}, '{8'h08, 8'h2a, 8'h08, 8'h22},
    '{8'h00, 8'h15, 8'h08, 8'h15}, '{8'h20, 8'hff, 8'h20, 8'h00}};

  io_port uut (.core_clk_i(clk), .nrst_i(nrst), .clk_en_i(cen),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
    .pwdata_i(pwd), .pstrb_i(pst), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(serr), .pin_in_i(pad), .pin_out_o(pout), .pin_oe_o(poe),
    .input_buf_en_o(ibuf), .periph_drive_i(pd), .analog_req_i(ar),
    .master_clear_pin_enable_i(mcen), .analog_path_en_o(apath),
    .digital_in_o(din), .timer_gate_input_o(gate));
  pin_model pm (.pin_out_i(pout), .pin_oe_i(poe), .ext_i(ext), .pad_o(pad));

  always #5 clk = ~clk;

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    pst <= s;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    re = serr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : xfer

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask : rdchk

  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].wa, {24'h0, rows[i].wd}, 4'h1);
      rdchk(rows[i].ra, {24'h0, rows[i].ex});
    end
    chk({31'h0, re}, 32'h1);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    ext <= 6'h3f;
    rdchk(8'h04, 32'h3f);
    rdchk(8'h0c, 32'h3f);
    rdchk(8'h10, 32'h0);
    rdchk(8'h00, 32'h0);
    xfer(1'b1, 8'h04, 32'h0, 4'h1);
    repeat (3) @(posedge clk);
    chk({26'h0, poe}, 32'h37);
    xfer(1'b1, 8'h0c, 32'h0, 4'h1);
    xfer(1'b1, 8'h08, 32'h05, 4'h1);
    ext <= 6'h28;
    repeat (4) @(posedge clk);
    rdchk(8'h00, 32'h0d);
    mcen <= 1'b1;
    rdchk(8'h00, 32'h05);
    rdchk(8'h08, 32'h05);
    mcen <= 1'b0;
    xfer(1'b1, 8'h04, 32'h3f, 4'h1);
    ext <= 6'h11;
    repeat (4) @(posedge clk);
    xfer(1'b1, 8'h00, 32'h0, 4'h0);
    rdchk(8'h08, 32'h11);
    ext <= 6'h10;
    repeat (5) @(posedge clk);
    chk({31'h0, gate}, 32'h1);
    chk({26'h0, ibuf}, 32'h3f);
    chk({26'h0, din}, 32'h10);
    xfer(1'b1, 8'h10, 32'h10, 4'h1);
    repeat (5) @(posedge clk);
    chk({31'h0, gate}, 32'h0);
    rdchk(8'h04, 32'h3f);
    pd[4] <= '{en: 3'b011, dat: 3'b010};
    repeat (3) @(posedge clk);
    chk({30'h0, poe[4], pout[4]}, 32'h2);
    pd[4] <= '{en: 3'b110, dat: 3'b010};
    ar[2] <= '{periph_en: 1'b1, mux_sel: 1'b1};
    ar[1] <= '{periph_en: 1'b1, mux_sel: 1'b0};
    xfer(1'b1, 8'h0c, 32'h3f, 4'h1);
    repeat (4) @(posedge clk);
    chk({30'h0, poe[4], pout[4]}, 32'h3);
    chk({14'h0, ibuf, din, apath}, 32'h4);
    xfer(1'b1, 8'h00, 32'h0, 4'h0);
    rdchk(8'h08, 32'h0);
    cen <= 1'b0;
    pd[4] <= '{en: 3'b001, dat: 3'b000};
    repeat (3) @(posedge clk);
    chk({30'h0, poe[4], pout[4]}, 32'h3);
    cen <= 1'b1;
    repeat (3) @(posedge clk);
    chk({30'h0, poe[4], pout[4]}, 32'h2);
    report_and_stop();
  end
endmodule : six_bit_io_port_with_pin_steering_test
